/* rtl/boot_map_pkg.sv */
/*
  package for the boot select and code map block: field layouts,
  reset values, start addresses and code-read decode types.
  assumes a single synchronous design clock domain.
*/
`default_nettype none
package boot_map_pkg;
  // ---------------------------------------------------------------
  // flash control values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0]  FLASH_CONTROL_HW_BOOT = 8'h00;
  localparam logic [7:0]  FLASH_CONTROL_NORMAL  = 8'hF0;
  localparam int          MAP_SELECT_LOW_BIT    = 1;
  localparam int          MAP_SELECT_HIGH_BIT   = 2;
  localparam int          COLUMN_LATCH_BIT      = 0;
  // ---------------------------------------------------------------
  // start addresses and vectors
  // ---------------------------------------------------------------
  localparam logic [15:0] USER_START_ADDR       = 16'h0000;
  localparam logic [15:0] BOOT_START_ADDR       = 16'hF800;
  localparam logic [7:0]  USER_BOOT_VECTOR_NONE = 8'hFC;
  localparam logic [7:0]  USER_BOOT_LOW_BYTE    = 8'h00;
  localparam logic [15:0] USER_TOP_ADDR         = 16'hF7FF;
  localparam int          EXTRA_ROW_ADDR_BITS   = 7;
  localparam logic        BOOT_JUMP_DELIVERED   = 1'b0;

  // where code executes
  typedef enum logic [1:0] {
    EXEC_USER,
    EXEC_BOOT,
    EXEC_EXTERNAL
  } exec_space_t;

  // target of a code read
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_USER_FLASH,
    TGT_BOOT_FLASH,
    TGT_EXTRA_ROW,
    TGT_SECURITY,
    TGT_EXTERNAL
  } read_target_t;

  // code-read request
  typedef struct packed {
    logic        valid;
    logic [15:0] data_pointer;
  } code_read_req_t;

  // code-read answer
  typedef struct packed {
    logic         valid;
    read_target_t target;
    logic [15:0]  addr;
  } code_read_rsp_t;

  // strap pin levels
  typedef struct packed {
    logic program_store_strobe;
    logic external_access_pin;
    logic address_latch_strobe;
  } straps_t;
endpackage
`default_nettype wire

/* rtl/boot_select_and_code_map.sv */
/*
  top of the boot select and code map block: strap capture at reset,
  start address choice, flash control state and code-read routing.
  assumes strap pins and cpu inputs are synchronous to ref_clk.
*/
`default_nettype none
module boot_select_and_code_map #(
  parameter logic [7:0] USER_BOOT_VECTOR_RESET = boot_map_pkg::USER_BOOT_VECTOR_NONE
)(
  input  wire logic            ref_clk,             // 125 MHz clock
  input  wire logic            nrst,                // async reset, low
  input  wire boot_map_pkg::straps_t straps,        // strap pin levels
  input  wire logic            boot_jump_select,    // stored jump bit
  input  wire logic [7:0]      user_boot_vector_in, // stored vector byte
  input  wire logic            flash_control_we,    // cpu write strobe
  input  wire logic [7:0]      flash_control_wdata, // cpu write data
  input  wire boot_map_pkg::exec_space_t exec_space, // fetch location
  input  wire boot_map_pkg::code_read_req_t read_req, // code read
  output logic                 boot_space_enable,   // boot space mapped
  output logic [7:0]           flash_control,       // control value
  output logic [15:0]          start_pc,            // first fetch addr
  output logic                 hw_boot,             // hw condition seen
  output logic [15:0]          user_boot_addr,      // user loader addr
  output logic                 user_boot_present,   // vector not FCh
  output logic                 unsupported,         // do-not-use read
  output var boot_map_pkg::code_read_rsp_t read_rsp // routed read
);
  import boot_map_pkg::*;

  // ---------------------------------------------------------------
  // reset release synchroniser
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic           captured;
    logic           boot_space_enable;
    logic [7:0]     flash_control;
    logic [15:0]    start_pc;
    logic           hw_boot;
    logic [7:0]     user_boot_vector;
    logic           unsupported;
    code_read_rsp_t read_rsp;
    logic [15:0]    user_boot_addr;
    logic           user_boot_present;
  } state_t;

  state_t state_q;
  state_t state_d;

  read_target_t dec_target;
  logic [15:0]  dec_addr;
  logic         dec_unsupported;

  // routing of the code read from current map state
  code_read_decode u_decode (
    .flash_control     (state_q.flash_control),
    .boot_space_enable (state_q.boot_space_enable),
    .exec_space        (exec_space),
    .data_pointer      (read_req.data_pointer),
    .unsupported       (dec_unsupported),
    .target            (dec_target),
    .addr              (dec_addr)
  );

  logic strap_hw;
  // the latch strobe pin is pulled up, so unconnected reads high
  assign strap_hw = !straps.program_store_strobe &&
                    straps.external_access_pin &&
                    straps.address_latch_strobe;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    // one capture right after release stands for the reset edge;
    // strap changes afterwards are never looked at again
    if (!state_q.captured) begin
      state_d.captured          = 1'b1;
      state_d.boot_space_enable = boot_jump_select;
      state_d.hw_boot           = strap_hw;
      state_d.user_boot_vector  = user_boot_vector_in;
      if (strap_hw) begin
        state_d.flash_control = FLASH_CONTROL_HW_BOOT;
        state_d.start_pc      = BOOT_START_ADDR;
      end else begin
        state_d.flash_control = FLASH_CONTROL_NORMAL;
        // cleared bit on delivered parts lands in the loader
        state_d.start_pc      = (boot_jump_select != BOOT_JUMP_DELIVERED) ?
                                USER_START_ADDR : BOOT_START_ADDR;
      end
    end else if (flash_control_we) begin
      state_d.flash_control = flash_control_wdata;
    end
    // loader address follows the stored vector, valid from the capture edge
    state_d.user_boot_addr    = {state_d.user_boot_vector, USER_BOOT_LOW_BYTE};
    state_d.user_boot_present = state_d.user_boot_vector != USER_BOOT_VECTOR_NONE;
    // read answer one cycle after request
    state_d.read_rsp.valid  = read_req.valid && state_q.captured;
    state_d.read_rsp.target = read_req.valid ? dec_target : TGT_NONE;
    state_d.read_rsp.addr   = read_req.valid ? dec_addr : 16'h0000;
    state_d.unsupported     = read_req.valid && dec_unsupported;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q                   <= '0;
      state_q.flash_control     <= FLASH_CONTROL_NORMAL;
      state_q.user_boot_vector  <= USER_BOOT_VECTOR_RESET;
      state_q.start_pc          <= USER_START_ADDR;
      state_q.read_rsp.target   <= TGT_NONE;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs
  assign boot_space_enable = state_q.boot_space_enable;
  assign flash_control     = state_q.flash_control;
  assign start_pc          = state_q.start_pc;
  assign hw_boot           = state_q.hw_boot;
  assign user_boot_addr    = state_q.user_boot_addr;
  assign user_boot_present = state_q.user_boot_present;
  assign unsupported       = state_q.unsupported;
  assign read_rsp          = state_q.read_rsp;
endmodule // boot_select_and_code_map
`default_nettype wire

/* rtl/code_read_decode.sv */
/*
  combinational decode of a code-read instruction onto a memory space.
  assumes flash control and boot-space enable are stable registered values.
*/
`default_nettype none
module code_read_decode
  import boot_map_pkg::*;
(
  input  wire logic [7:0]      flash_control,      // map select bits
  input  wire logic            boot_space_enable,  // boot space mapped
  input  wire exec_space_t     exec_space,         // where code runs
  input  wire logic [15:0]     data_pointer,       // read address
  output logic                 unsupported,        // do-not-use range
  output read_target_t         target,             // selected space
  output logic [15:0]          addr                // address in space
);
  logic map_high;
  logic map_low;
  assign map_high = flash_control[MAP_SELECT_HIGH_BIT];
  assign map_low  = flash_control[MAP_SELECT_LOW_BIT];

  // -------------------------------------------------------------
  // space selection
  // -------------------------------------------------------------
  always_comb begin
    target      = TGT_NONE;
    addr        = data_pointer;
    unsupported = 1'b0;
    case (exec_space)
      EXEC_USER, EXEC_BOOT: begin
        if (exec_space == EXEC_BOOT && !boot_space_enable &&
            (map_high ^ map_low)) begin
          target = TGT_NONE;
        end else if (!map_high && map_low) begin
          target = TGT_EXTRA_ROW;
          // upper pointer bits are not decoded, so they alias
          addr   = {9'h000, data_pointer[EXTRA_ROW_ADDR_BITS-1:0]};
        end else if (map_high && !map_low) begin
          target = TGT_SECURITY;
          addr   = 16'h0000;
        end else if (boot_space_enable && data_pointer > USER_TOP_ADDR) begin
          if (exec_space == EXEC_BOOT && !map_high) begin
            target = TGT_BOOT_FLASH;
          end else begin
            target      = TGT_USER_FLASH;
            unsupported = 1'b1;
          end
        end else if (exec_space == EXEC_BOOT && !boot_space_enable &&
                     map_high) begin
          target = TGT_NONE;
        end else begin
          target = TGT_USER_FLASH;
        end
      end
      EXEC_EXTERNAL: begin
        target = map_low ? TGT_NONE : TGT_EXTERNAL;
      end
      default: begin
        target = TGT_NONE;
      end
    endcase
  end
endmodule // code_read_decode
`default_nettype wire

/* verification/boot_select_and_code_map_bench.sv */
/*
  bench for the boot select and code map block: strap boots and code reads.
  assumes the strap model and checker files compile before this one.
*/
`default_nettype none
module boot_select_and_code_map_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import boot_map_pkg::*;
  logic ref_clk, nrst, hw_mode, let_go, bjs, we, hw_boot, bse, ubp, unsup;
  logic [7:0] vec, wd, fc;
  logic [15:0] spc, uba;
  exec_space_t ex;
  code_read_req_t rq;
  code_read_rsp_t rs;
  straps_t straps;
  int n_errors, samples_checked, cyc;
  strap_model u_straps (.hw_mode(hw_mode), .let_go(let_go), .straps(straps));
  boot_select_and_code_map u_dut (.ref_clk(ref_clk), .nrst(nrst), .straps(straps),
    .boot_jump_select(bjs), .user_boot_vector_in(vec), .flash_control_we(we),
    .flash_control_wdata(wd), .exec_space(ex), .read_req(rq),
    .boot_space_enable(bse), .flash_control(fc), .start_pc(spc), .hw_boot(hw_boot),
    .user_boot_addr(uba), .user_boot_present(ubp), .unsupported(unsup), .read_rsp(rs));
  // ---------------------------------------------------------------
  // shared tasks; inputs move 1 ns after the edge
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  // board lets go only after capture, else the sample would race it
  task automatic boot(input logic hw, input logic j, input logic [7:0] v);
    hw_mode = hw;
    bjs = j;
    vec = v;
    let_go = 1'b0;
    nrst = 1'b0;
    repeat (5) step();
    nrst = 1'b1;
    repeat (3) step();
    let_go = 1'b1;
    step();
  endtask
  task automatic wr(input logic [7:0] v);
    rq.valid = 1'b0;
    we = 1'b1;
    wd = v;
    step();
    we = 1'b0;
    chk(fc, v);
    step();
  endtask
  // request stays up so back-to-back reads need no gap
  task automatic rd(input exec_space_t e, input logic [15:0] dp,
                    input read_target_t t, input logic [15:0] a, input logic u);
    ex = e;
    rq = {1'b1, dp};
    step();
    chk(rs.valid, 1'b1);
    chk(rs.target, t);
    if (t != TGT_NONE) chk(rs.addr, a);
    chk(unsup, u);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_straps();
    logic hw, j;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      hw = i[1];
      j = i[0];
      v = j ? 8'h7A : 8'hFC;
      boot(hw, j, v);
      chk(hw_boot, hw);
      chk(fc, hw ? 8'h00 : 8'hF0);
      chk(spc, (hw || !j) ? 16'hF800 : 16'h0000);
      chk(bse, j);
      chk(uba, {v, 8'h00});
      chk(ubp, v != 8'hFC);
    end
  endtask
  task automatic t_map_on();
    boot(1'b0, 1'b1, 8'hFC);
    wr(8'h00);
    rd(EXEC_USER, 16'h1234, TGT_USER_FLASH, 16'h1234, 1'b0);
    rd(EXEC_USER, 16'hF900, TGT_USER_FLASH, 16'hF900, 1'b1);
    rd(EXEC_BOOT, 16'hF900, TGT_BOOT_FLASH, 16'hF900, 1'b0);
    wr(8'h02);
    rd(EXEC_USER, 16'hFF85, TGT_EXTRA_ROW, 16'h0005, 1'b0);
    rd(EXEC_BOOT, 16'h007F, TGT_EXTRA_ROW, 16'h007F, 1'b0);
    wr(8'h04);
    rd(EXEC_USER, 16'hABCD, TGT_SECURITY, 16'h0000, 1'b0);
    rd(EXEC_BOOT, 16'h0000, TGT_SECURITY, 16'h0000, 1'b0);
    rd(EXEC_EXTERNAL, 16'h0100, TGT_EXTERNAL, 16'h0100, 1'b0);
    wr(8'h02);
    rd(EXEC_EXTERNAL, 16'h0100, TGT_NONE, 16'h0000, 1'b0);
    wr(8'h06);
    rd(EXEC_USER, 16'h1234, TGT_USER_FLASH, 16'h1234, 1'b0);
    rd(EXEC_EXTERNAL, 16'h0100, TGT_NONE, 16'h0000, 1'b0);
    rq.valid = 1'b0;
  endtask
  task automatic t_map_off();
    boot(1'b0, 1'b0, 8'hFC);
    wr(8'h02);
    rd(EXEC_BOOT, 16'h0010, TGT_NONE, 16'h0000, 1'b0);
    wr(8'h04);
    rd(EXEC_BOOT, 16'h0010, TGT_NONE, 16'h0000, 1'b0);
    wr(8'h06);
    rd(EXEC_BOOT, 16'h0010, TGT_NONE, 16'h0000, 1'b0);
    wr(8'h00);
    rd(EXEC_BOOT, 16'h1234, TGT_USER_FLASH, 16'h1234, 1'b0);
    rq.valid = 1'b0;
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // cycle ceiling well above the roughly 90 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    {nrst, hw_mode, let_go, bjs, we, vec, wd} = '0;
    ex = EXEC_USER;
    rq = '0;
    t_straps();
    t_map_on();
    t_map_off();
    close_out();
  end
endmodule // boot_select_and_code_map_bench
`default_nettype wire

/* verification/boot_select_and_code_map_monitor.sv */
/*
  port checker for the boot select and code map block.
  assumes capture three edges after nrst rises, as the top synchronises it.
*/
`default_nettype none
module boot_select_and_code_map_monitor
  import boot_map_pkg::*;
(
  input wire logic           ref_clk,             // clock
  input wire logic           nrst,                // reset, low
  input wire straps_t        straps,              // straps
  input wire logic           boot_jump_select,    // jump bit
  input wire logic [7:0]     user_boot_vector_in, // vector
  input wire code_read_req_t read_req,            // read in
  input wire logic           boot_space_enable,   // boot map
  input wire logic [7:0]     flash_control,       // control
  input wire logic [15:0]    start_pc,            // start
  input wire logic           hw_boot,             // hw seen
  input wire logic [15:0]    user_boot_addr,      // loader
  input wire logic           user_boot_present,   // loader set
  input wire logic           unsupported,         // bad read
  input wire code_read_rsp_t read_rsp             // read out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // edges since release; 2 marks the capture edge
  // ---------------------------------------------------------------
  logic [1:0] up_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_enable_copy: assert property (up_q == 2'h2 |=>
    boot_space_enable == $past(boot_jump_select)) else $error("enable copy");
  a_hw_detect: assert property (up_q == 2'h2 |=> hw_boot ==
    (!$past(straps.program_store_strobe) && $past(straps.external_access_pin)
    && $past(straps.address_latch_strobe))) else $error("hw detect");
  a_hw_start: assert property (up_q == 2'h2 ##1 hw_boot |->
    flash_control == 8'h00 && start_pc == 16'hF800) else $error("hw start");
  a_normal_ctl: assert property (up_q == 2'h2 ##1 !hw_boot |->
    flash_control == 8'hF0) else $error("normal control");
  a_start_sel: assert property (up_q == 2'h2 |=> hw_boot ||
    start_pc == ($past(boot_jump_select) ? 16'h0000 : 16'hF800)) else $error("start");
  a_capture_hold: assert property (up_q == 2'h3 |=> $stable(hw_boot)
    && $stable(boot_space_enable) && $stable(start_pc)) else $error("hold");
  a_vector_addr: assert property (up_q == 2'h2 |=>
    user_boot_addr == {$past(user_boot_vector_in), 8'h00} &&
    user_boot_present == ($past(user_boot_vector_in) != 8'hFC)) else $error("vec");
  a_read_answer: assert property (up_q == 2'h3 && read_req.valid |=>
    read_rsp.valid) else $error("no answer");
  a_no_spurious: assert property (!read_req.valid |=>
    !read_rsp.valid && !unsupported) else $error("spurious");
  c_hw: cover property (hw_boot);
  c_row: cover property (read_rsp.valid && read_rsp.target == TGT_EXTRA_ROW);
  c_bad: cover property (unsupported);
endmodule // boot_select_and_code_map_monitor
bind boot_select_and_code_map boot_select_and_code_map_monitor u_mon (
  .ref_clk             (ref_clk),
  .nrst                (nrst),
  .straps              (straps),
  .boot_jump_select    (boot_jump_select),
  .user_boot_vector_in (user_boot_vector_in),
  .read_req            (read_req),
  .boot_space_enable   (boot_space_enable),
  .flash_control       (flash_control),
  .start_pc            (start_pc),
  .hw_boot             (hw_boot),
  .user_boot_addr      (user_boot_addr),
  .user_boot_present   (user_boot_present),
  .unsupported         (unsupported),
  .read_rsp            (read_rsp)
);
`default_nettype wire

/* verification/strap_model.sv */
/*
  strap pin model: the levels an outside board puts on the straps.
  assumes the bench says when a hardware boot is wanted and when to let go.
*/
`default_nettype none
module strap_model
  import boot_map_pkg::*;
(
  input  wire logic hw_mode, // ask for hardware boot
  input  wire logic let_go,  // board has let go
  output var straps_t straps // pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // let-go strobe and access lines flip, so a late sample is caught;
  // the latch strobe has a pull-up and floats high once let go
  always_comb begin
    straps = hw_mode ? straps_t'(3'h3) : straps_t'(3'h7);
    if (let_go) begin
      straps.program_store_strobe = !straps.program_store_strobe;
      straps.external_access_pin  = !straps.external_access_pin;
      straps.address_latch_strobe = 1'b1;
    end
  end
endmodule // strap_model
`default_nettype wire
